// >>> hdl/frame_pkg.sv
/*
  Package for the bus framing and initiator-ready block: widths, depths,
  transfer kinds and line levels shared by the design files.
  Assumes nothing of its surroundings.
*/
package frame_pkg;
  localparam int  DATA_W       = 32;
  localparam int  FIFO_DEPTH   = 32;
  localparam int  BURST_W      = 8;
  localparam logic DEASSERTED  = 1'b1;
  localparam logic ASSERTED    = 1'b0;
  localparam logic DIR_READ    = 1'b0;
  localparam logic DIR_WRITE   = 1'b1;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_TURN} master_state_e;
endpackage

// >>> hdl/word_stream_if.sv
/*
  Valid/ready word stream between the framing engine and its FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface word_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// >>> hdl/word_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  word_stream_if.dst  wr,
  word_stream_if.src  rd,
  output logic        full,
  output logic        empty
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("word_fifo depth must be a power of two of at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;

  // Full when pointers differ only in the wrap bit.
  assign empty    = (wptr_q == rptr_q);
  assign full     = (wptr_q[AW] != rptr_q[AW])
                    && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_q[AW-1:0]];

  // Storage write on an accepted word.
  always_ff @(posedge clk_sys) begin
    if (wr.valid && !full) begin
      mem[wptr_q[AW-1:0]] <= wr.data;
    end
  end

  // Pointer advance on each side's handshake.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (wr.valid && !full) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (rd.ready && !empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule

// >>> hdl/data_phase_tracker.sv
/*
  Watches the shared frame and ready lines and reports data-phase
  completion and the final phase of a transaction.
  Assumes its inputs are bus lines that are synchronous to clk_sys.
*/
`timescale 1ns/10ps
module data_phase_tracker
  import frame_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic frame_n,
  input  wire logic irdy_n,
  input  wire logic trdy_n,
  output logic      phase_done,
  output logic      last_done,
  output logic      bus_busy
);
  logic frame_seen_q;

  // A phase completes only when both ready lines read asserted.
  assign phase_done = (irdy_n == ASSERTED) && (trdy_n == ASSERTED);
  // Frame released during a completing phase marks the final one.
  assign last_done  = phase_done && (frame_n == DEASSERTED);
  assign bus_busy   = frame_seen_q || (frame_n == ASSERTED);

  // Tracks whether a transaction is open on the bus.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_seen_q <= 1'b0;
    end else if (frame_n == ASSERTED) begin
      frame_seen_q <= 1'b1;
    end else if (last_done) begin
      frame_seen_q <= 1'b0;
    end
  end
endmodule

// >>> hdl/frame_initiator.sv
/*
  Bus master framing and initiator-ready engine. Drives the frame and
  initiator-ready lines, paces data phases against target-ready, buffers
  write data in a FIFO and returns read data.
  Assumes address, command, parity and stop handling live elsewhere in the
  bus unit; the target paces phases with target-ready; the shared lines are
  resolved outside from the enables given here.
  The bus lines are synchronous to clk_sys, so they are sampled as they
  stand at each rising edge. A phase is counted on exactly the edge on
  which both ready lines are low. Ready is withdrawn for one cycle after
  each completed phase, which lets the data register and the FIFO head
  settle before the next phase is offered.
*/
`timescale 1ns/10ps
module frame_initiator
  import frame_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               bus_grant,
  input  wire logic               start,
  input  wire logic               dir_write,
  input  wire logic [BURST_W-1:0] burst_len,
  output logic                    busy,
  input  wire logic               wr_valid,
  input  wire logic [WIDTH-1:0]   wr_data,
  output logic                    wr_ready,
  output logic                    rd_valid,
  output logic [WIDTH-1:0]        rd_data,
  input  wire logic               rd_ready,
  output logic                    done,
  input  wire logic               frame_n_in,
  output logic                    frame_n_out,
  output logic                    frame_n_oe,
  input  wire logic               irdy_n_in,
  output logic                    irdy_n_out,
  output logic                    irdy_n_oe,
  input  wire logic               trdy_n_in,
  input  wire logic [WIDTH-1:0]   ad_in,
  output logic [WIDTH-1:0]        ad_out,
  output logic                    ad_oe,
  output logic                    addr_phase
);
  initial begin
    if (WIDTH < 1 || DEPTH < 2) begin
      $error("frame_initiator width or depth out of range");
    end
    if (BURST_W < 2) begin
      $error("frame_initiator burst counter too narrow");
    end
  end

  master_state_e      state_q;
  logic               dir_q;
  logic [BURST_W-1:0] left_q;
  logic               take;
  logic [BURST_W-1:0] left_nx;
  logic               irdy_nx;
  logic               frame_nx;
  logic               wr_able;
  logic               rd_able;
  logic               fifo_full;
  logic               fifo_empty;
  logic               phase_done;
  logic               last_done;
  logic               bus_busy;
  logic               own_phase;
  logic               can_go;
  logic               final_phase;
  logic [WIDTH-1:0]   rd_data_q;
  logic               rd_valid_q;

  word_stream_if #(.W(WIDTH)) in_s ();
  word_stream_if #(.W(WIDTH)) out_s ();

  // The bus lines are read straight from the pins: the bus runs on this
  // same clock, and any added stage would let the pins complete phases
  // that the engine has not yet counted.

  // One place decides whether an idle request may be taken, so the
  // sequencer and the line drivers always agree on the same edge.
  function automatic logic start_ok(
    input logic               req,
    input logic               grant,
    input logic               other_busy,
    input logic [BURST_W-1:0] len
  );
    return req && grant && !other_busy && (len != '0);
  endfunction

  assign take = start_ok(start, bus_grant, bus_busy, burst_len);

  // Bus observer for the shared lines; it also sees other masters, so a
  // foreign transaction keeps the engine from starting its own.
  data_phase_tracker u_tracker (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .frame_n    (frame_n_in),
    .irdy_n     (irdy_n_in),
    .trdy_n     (trdy_n_in),
    .phase_done (phase_done),
    .last_done  (last_done),
    .bus_busy   (bus_busy)
  );

  // Write data from the user passes through the FIFO.
  assign in_s.valid  = wr_valid;
  assign in_s.data   = wr_data;
  assign wr_ready    = in_s.ready;

  word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wr      (in_s),
    .rd      (out_s),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );

  // Our own phase completes when our ready and the target's meet.
  assign own_phase   = (state_q == ST_DATA) && phase_done;
  assign final_phase = (left_q == BURST_W'(1));
  // Able to complete: a write needs a buffered word, a read needs a slot
  // that stays free whatever the consumer does in the coming cycle. No
  // phase is offered in the cycle right after one completes.
  assign wr_able = !fifo_empty;
  assign rd_able = !(rd_valid_q && !rd_ready);
  assign can_go  = !own_phase && (dir_q ? wr_able : rd_able);
  assign out_s.ready = own_phase && dir_q;

  // Next-cycle intent for the phase counter and the two lines we drive.
  always_comb begin
    left_nx  = left_q;
    irdy_nx  = DEASSERTED;
    frame_nx = ASSERTED;
    if (own_phase) begin
      left_nx = left_q - BURST_W'(1);
    end
    if (own_phase && final_phase) begin
      // Last phase done: both lines go back to their idle level.
      irdy_nx  = DEASSERTED;
      frame_nx = DEASSERTED;
    end else begin
      irdy_nx = can_go ? ASSERTED : DEASSERTED;
      // Frame is released together with ready for the final phase and
      // then stays released, so the last phase is marked for as long as
      // it is offered to the target.
      if (left_nx == BURST_W'(1)
          && (irdy_nx == ASSERTED || frame_n_out == DEASSERTED)) begin
        frame_nx = DEASSERTED;
      end else begin
        frame_nx = ASSERTED;
      end
    end
  end

  // Transaction sequencer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      dir_q   <= DIR_READ;
      left_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_ADDR;
            dir_q   <= dir_write;
            left_q  <= burst_len;
          end
        end
        ST_ADDR: begin
          state_q <= ST_DATA;
        end
        ST_DATA: begin
          if (own_phase) begin
            left_q <= left_nx;
            if (final_phase) begin
              state_q <= ST_TURN;
            end
          end
        end
        ST_TURN: begin
          // Two cycles with both lines high (this one and the first idle cycle) before the enables drop, so
          // the lines are left at their idle level when released.
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Frame and initiator-ready drives, registered from next-cycle intent.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_n_out <= DEASSERTED;
      irdy_n_out  <= DEASSERTED;
      frame_n_oe  <= 1'b0;
      irdy_n_oe   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // The enables rise with frame; ready waits for the first phase.
          if (take) begin
            frame_n_out <= ASSERTED;
            frame_n_oe  <= 1'b1;
            irdy_n_oe   <= 1'b1;
            irdy_n_out  <= DEASSERTED;
          end else begin
            frame_n_oe  <= 1'b0;
            irdy_n_oe   <= 1'b0;
          end
        end
        ST_ADDR, ST_DATA: begin
          frame_n_out <= frame_nx;
          irdy_n_out  <= irdy_nx;
        end
        ST_TURN: begin
          frame_n_out <= DEASSERTED;
          irdy_n_out  <= DEASSERTED;
        end
        default: begin
          frame_n_out <= DEASSERTED;
          irdy_n_out  <= DEASSERTED;
        end
      endcase
    end
  end

  // Write data and its enable follow the head of the FIFO. The enable
  // rises when the address cycle ends, with ready for the first phase if a word is buffered, and holds until the last ends;
  // after a pop the register shows the new head from the same edge on which ready returns.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ad_out <= '0;
      ad_oe  <= 1'b0;
    end else begin
      ad_out <= out_s.data;
      ad_oe  <= dir_q
                && ((state_q == ST_ADDR)
                    || (state_q == ST_DATA && !(own_phase && final_phase)));
    end
  end

  // Read data is captured on a completed phase where the target supplies it.
  // A new word and the consumer taking the old one may share an edge; the
  // new word wins the slot, so nothing is lost.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      if (own_phase && !dir_q) begin
        rd_data_q  <= ad_in;
        rd_valid_q <= 1'b1;
      end else if (rd_ready) begin
        rd_valid_q <= 1'b0;
      end
    end
  end

  // Completion pulse and status. The pulse follows the edge on which the
  // final phase completed, when both lines are already high again.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= own_phase && final_phase;
    end
  end

  assign rd_data    = rd_data_q;
  assign rd_valid   = rd_valid_q;
  assign busy       = (state_q != ST_IDLE);
  assign addr_phase = (state_q == ST_ADDR);
endmodule

// >>> test/frame_initiator_monitor.sv
/* Checker for the framing engine's pin-side outputs.
   Assumes it is bound to frame_initiator and sees only its ports. */
`timescale 1ns/10ps
module frame_initiator_monitor
  import frame_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               bus_grant,
  input wire logic               start,
  input wire logic               dir_write,
  input wire logic [BURST_W-1:0] burst_len,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               frame_n_out,
  input wire logic               frame_n_oe,
  input wire logic               irdy_n_out,
  input wire logic               irdy_n_oe,
  input wire logic               ad_oe,
  input wire logic               addr_phase
);
  logic dir_q;
  logic take;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // A request is taken when idle, granted and not empty.
  assign take = start && bus_grant && !busy && burst_len != 8'h00;
  // Remembers the direction of the transfer in flight.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      dir_q <= DIR_READ;
    else if (take)
      dir_q <= dir_write;
  end
  // Frame, ready, data-enable, done and address-cycle outputs against their causes.
  start_frame_a: assert property (take |=> !frame_n_out && frame_n_oe)
    else $error("frame not asserted after a taken start");
  frame_drive_a: assert property (!frame_n_out |-> frame_n_oe)
    else $error("frame low without its enable");
  irdy_drive_a: assert property (!irdy_n_out |-> irdy_n_oe)
    else $error("ready low without its enable");
  last_mark_a: assert property ($rose(frame_n_out) |-> !irdy_n_out)
    else $error("frame released without ready");
  write_data_a: assert property (!irdy_n_out && dir_q |-> ad_oe)
    else $error("write ready without driven data");
  read_free_a: assert property (!irdy_n_out && !dir_q |-> !ad_oe)
    else $error("data lines driven during a read");
  done_idle_a: assert property (done |-> irdy_n_out && frame_n_out)
    else $error("done while frame or ready still low");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  txn_end_a: assert property (take |-> ##[2:1000] done)
    else $error("transaction did not finish");
  addr_cycle_a: assert property (take |=> addr_phase)
    else $error("address cycle not marked after a taken start");
  // Main scenarios seen.
  cover property (take && dir_write);
  cover property (take && !dir_write);
  cover property (start && !take);
endmodule
bind frame_initiator frame_initiator_monitor mon_u (.clk_sys, .resetn,
  .bus_grant, .start, .dir_write, .burst_len, .busy, .done, .frame_n_out,
  .frame_n_oe, .irdy_n_out, .irdy_n_oe, .ad_oe, .addr_phase);

// >>> test/target_model.sv
/* Target model: paces data phases with target-ready, supplies read data.
   Assumes frame and initiator-ready arrive as resolved pin levels. */
`timescale 1ns/10ps
module target_model
  import frame_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         frame_n,
  input  wire logic         irdy_n,
  input  wire logic         dir_write,
  input  wire logic         slow,
  output logic              trdy_n,
  output logic [DATA_W-1:0] ad
);
  logic              act_q;
  logic              rdy_q;
  logic [DATA_W-1:0] dat_q;
  logic              fin;
  logic              more;
  // A phase ends where both ready lines are low; frame high marks the last.
  assign fin = rdy_q && !irdy_n;
  assign more = !(fin && frame_n) && (act_q || !frame_n);
  // Released target-ready goes to its pull-up level.
  assign trdy_n = !rdy_q;
  // Read data only while ready; otherwise an inverted pattern.
  assign ad = (rdy_q && dir_write == DIR_READ) ? dat_q : ~dat_q;
  // Follows the transaction and offers ready, at random when slow.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      act_q <= 1'b0;
      rdy_q <= 1'b0;
      dat_q <= 32'h0000_1000;
    end else begin
      act_q <= more;
      rdy_q <= more && (!slow || $urandom_range(1) == 1);
      if (fin)
        dat_q <= dat_q + 32'h1;
    end
  end
endmodule

// >>> test/frame_initiator_tb.sv
/* Bench for frame_initiator: write and read bursts against a target model.
   Assumes the monitor and target model files are compiled first. */
`timescale 1ns/10ps
module frame_initiator_tb
  import frame_pkg::*;
;
  logic clk_sys, resetn, bus_grant, start, dir_write, rd_ready, wr_valid;
  logic busy, wr_ready, rd_valid, done, frame_n_out, frame_n_oe, slow;
  logic irdy_n_out, irdy_n_oe, ad_oe, trdy_w;
  logic [BURST_W-1:0] burst_len;
  logic [DATA_W-1:0]  wr_data, rd_data, ad_out, t_ad, ad_w;
  logic [DATA_W-1:0]  wq[$], rq[$];
  logic [DATA_W-1:0]  tgt_nx = 32'h0000_1000;
  int                 n_mismatch, checks_done, n_ph;
  wire frame_w = frame_n_oe ? frame_n_out : 1'b1;
  wire irdy_w = irdy_n_oe ? irdy_n_out : 1'b1;
  assign ad_w = ad_oe ? ad_out : t_ad;
  frame_initiator dut_u (.clk_sys, .resetn, .bus_grant, .start, .dir_write,
    .burst_len, .busy, .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data,
    .rd_ready, .done, .frame_n_in(frame_w), .frame_n_out, .frame_n_oe,
    .irdy_n_in(irdy_w), .irdy_n_out, .irdy_n_oe, .trdy_n_in(trdy_w),
    .ad_in(ad_w), .ad_out, .ad_oe, .addr_phase());
  target_model tgt_u (.clk_sys, .resetn, .frame_n(frame_w), .irdy_n(irdy_w),
    .dir_write, .slow, .trdy_n(trdy_w), .ad(t_ad));
  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Phases completed at the pins and the read handshake, seen mid-cycle.
  always @(negedge clk_sys) begin
    if (resetn && !irdy_w && !trdy_w) begin
      n_ph++;
      if (dir_write) chk("wdata", ad_w, wq.pop_front());
      else begin
        chk("rbus", ad_w, tgt_nx);
        rq.push_back(tgt_nx);
      end
      tgt_nx++;
    end
    if (rd_valid === 1'b1 && rd_ready) chk("rdata", rd_data, rq.pop_front());
  end
  // Random stalls on the read side.
  always @(posedge clk_sys) begin
    #1 rd_ready = $urandom_range(1);
  end
  task automatic refuse(input logic g, input int len);
    bus_grant = g;
    burst_len = len[BURST_W-1:0];
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    chk("idle", {busy, frame_n_oe, irdy_n_oe}, 0);
    bus_grant = 1'b1;
  endtask
  task automatic txn(input logic dw, input int len);
    int i;
    dir_write = dw;
    slow = $urandom_range(1);
    for (i = 0; dw && i < len + (len == FIFO_DEPTH); i++) begin
      chk("wr_ready", wr_ready, i < FIFO_DEPTH);
      wr_data = $urandom;
      wr_valid = 1'b1;
      if (i < FIFO_DEPTH)
        wq.push_back(wr_data);
      tick(1);
    end
    wr_valid = 1'b0;
    n_ph = 0;
    burst_len = len[BURST_W-1:0];
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++)
      tick(1);
    if (i == 2000) begin
      n_mismatch++;
      give_verdict();
    end
    for (i = 0; i < 200 && rq.size() != 0; i++)
      tick(1);
    tick(4);
    chk("phases", n_ph, len);
    chk("left", wq.size() + rq.size(), 0);
    $display("burst write %0d length %0d ended", dw, len);
  endtask
  initial begin
    void'($urandom(8));
    {resetn, bus_grant, start, dir_write, wr_valid, slow} = 6'h10;
    burst_len = 8'h00;
    wr_data = 32'h0;
    rd_ready = 1'b0;
    tick(16);
    chk("reset", {wr_ready, frame_n_oe, irdy_n_oe, ad_oe, busy, done}, 6'h20);
    resetn = 1'b1;
    tick(1);
    refuse(1'b1, 0);
    refuse(1'b0, 1);
    txn(1'b1, 1);
    txn(1'b0, 1);
    txn(1'b1, 2);
    txn(1'b0, 2);
    txn(1'b1, FIFO_DEPTH);
    repeat (6) txn($urandom_range(1), $urandom_range(31, 1));
    give_verdict();
  end
endmodule
